// file: hw/hpag_top.sv
// Our own choices: the placing of the registers and register access over Wishbone.
module hpag_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic boot_strap_in,
  input wire logic power_guard_in,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire hpag_pkg::hpag_host_in_type host_in,
  output hpag_pkg::hpag_host_out_type host_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [hpag_pkg::CTRL_W-1:0] ctrl_r;
  logic [hpag_pkg::PIN_W-1:0] pfc_r;
  logic [31:0] window_r;
  logic [31:0] aux_r;
  logic boot_mode_r;
  logic wr_prev_r;
  logic ack_r;
  logic [31:0] dat_r;
  hpag_pkg::hpag_host_out_type hout_r;
  hpag_pkg::hpag_host_out_type hout_nxt;

  // reset and mode view
  wire logic in_rst = ~reset_pin_n;
  wire logic boot_now = in_rst ? boot_strap_in : boot_mode_r;
  wire logic guard = power_guard_in;
  wire logic boot_live = ~in_rst & guard;
  wire logic cfg_live = ~in_rst & pfc_r[hpag_pkg::PIN_GUARD] & guard;

  // per-pin host function enable
  wire logic [hpag_pkg::PIN_W-1:0] host_en = boot_now ? {hpag_pkg::PIN_W{boot_live}}
                                                      : ({hpag_pkg::PIN_W{cfg_live}} & pfc_r);

  // host strobes seen only through enabled input buffers
  wire logic sel_act = host_en[hpag_pkg::PIN_CS] & ~host_in.select_n;
  wire logic rs_act = host_en[hpag_pkg::PIN_RS] & host_in.reg_select;
  wire logic rd_act = host_en[hpag_pkg::PIN_RD] & ~host_in.read_n;
  wire logic wr_act = host_en[hpag_pkg::PIN_WR] & ~host_in.write_n;
  wire logic rd_go = sel_act & rd_act & host_en[hpag_pkg::PIN_BUS];
  wire logic wr_go = sel_act & wr_act & ~wr_prev_r & host_en[hpag_pkg::PIN_BUS];

  ////////////////////////////////////////////////////////////////////////////
  // alignment lane, window when register select is high
  wire logic [31:0] lane_word = rs_act ? window_r : aux_r;
  wire logic lane_swap = rs_act & ctrl_r[hpag_pkg::CTRL_SWAP_BIT];
  logic [15:0] lane_half;
  logic [31:0] lane_merged;

  hpag_lane i_hpag_lane (
    .word(lane_word),
    .swap(lane_swap),
    .order_inv(ctrl_r[hpag_pkg::CTRL_ORDER_BIT]),
    .byte_sel_hi(host_in.byte_sel[1]),
    .bus_in(host_in.bus),
    .half_out(lane_half),
    .word_merged(lane_merged)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  wire logic wb_hit = wb_cyc_i & wb_stb_i;
  wire logic wb_wr = wb_hit & ack_r & wb_we_i;
  wire logic [31:0] ctrl_wide = {{(32-hpag_pkg::CTRL_W){1'b0}}, ctrl_r};
  wire logic [31:0] pfc_wide = {{(32-hpag_pkg::PIN_W){1'b0}}, pfc_r};
  wire logic [31:0] ctrl_wnew = hpag_pkg::lane_merge(ctrl_wide, wb_dat_i, wb_sel_i);
  wire logic [31:0] pfc_wnew = hpag_pkg::lane_merge(pfc_wide, wb_dat_i, wb_sel_i);
  wire logic [4:0] raw_pins = {host_in.select_n, host_in.reg_select, host_in.write_n, host_in.read_n, guard};
  wire logic [31:0] status_word = {19'h00000, raw_pins, 5'h00, in_rst, guard, boot_mode_r};
  logic [31:0] rd_mux;

  // read data select, unmapped reads as zero
  always_comb
  begin
    case (wb_adr_i)
      hpag_pkg::CTRL_OFS: rd_mux = ctrl_wide;
      hpag_pkg::PINCFG_OFS: rd_mux = pfc_wide;
      hpag_pkg::WINDOW_OFS: rd_mux = window_r;
      hpag_pkg::AUX_OFS: rd_mux = aux_r;
      hpag_pkg::STATUS_OFS: rd_mux = status_word;
      hpag_pkg::RAWBUS_OFS: rd_mux = {16'h0000, host_in.bus};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus handshake, ack one cycle after the request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      dat_r <= hpag_pkg::WORD_RST;
    end
    else
    begin
      ack_r <= wb_hit & ~ack_r;
      dat_r <= (wb_hit & ~ack_r) ? rd_mux : dat_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // software registers; host write to the same word wins
  wire logic wb_win = wb_wr & (wb_adr_i == hpag_pkg::WINDOW_OFS);
  wire logic wb_aux = wb_wr & (wb_adr_i == hpag_pkg::AUX_OFS);
  wire logic [31:0] window_nxt = (wr_go & rs_act) ? lane_merged
                               : (wb_win ? hpag_pkg::lane_merge(window_r, wb_dat_i, wb_sel_i) : window_r);
  wire logic [31:0] aux_nxt = (wr_go & ~rs_act) ? lane_merged
                            : (wb_aux ? hpag_pkg::lane_merge(aux_r, wb_dat_i, wb_sel_i) : aux_r);
  wire logic ctrl_we = wb_wr & (wb_adr_i == hpag_pkg::CTRL_OFS);
  wire logic pfc_we = wb_wr & (wb_adr_i == hpag_pkg::PINCFG_OFS);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= hpag_pkg::CTRL_RST;
      pfc_r <= hpag_pkg::PINCFG_RST;
      window_r <= hpag_pkg::WORD_RST;
      aux_r <= hpag_pkg::WORD_RST;
    end
    else
    begin
      ctrl_r <= ctrl_we ? ctrl_wnew[hpag_pkg::CTRL_W-1:0] : ctrl_r;
      pfc_r <= in_rst ? hpag_pkg::PINCFG_RST : (pfc_we ? pfc_wnew[hpag_pkg::PIN_W-1:0] : pfc_r);
      window_r <= window_nxt;
      aux_r <= aux_nxt;
    end
  end

  // strap caught while the device reset pin is held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_mode_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end
    else
    begin
      boot_mode_r <= in_rst ? boot_strap_in : boot_mode_r;
      wr_prev_r <= sel_act & wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin buffer control
  always_comb
  begin
    hout_nxt.ready = host_en[hpag_pkg::PIN_READY] & ctrl_r[hpag_pkg::CTRL_READY_BIT];
    hout_nxt.ready_oe = (in_rst & boot_strap_in) | host_en[hpag_pkg::PIN_READY];
    hout_nxt.irq = host_en[hpag_pkg::PIN_IRQ] & ctrl_r[hpag_pkg::CTRL_IRQ_BIT];
    hout_nxt.irq_oe = host_en[hpag_pkg::PIN_IRQ];
    hout_nxt.dreq = host_en[hpag_pkg::PIN_DREQ] & ctrl_r[hpag_pkg::CTRL_DREQ_BIT];
    hout_nxt.dreq_oe = host_en[hpag_pkg::PIN_DREQ];
    hout_nxt.bus_out = rd_go ? lane_half : 16'h0000;
    hout_nxt.bus_oe = rd_go;
    hout_nxt.in_en = {host_en[hpag_pkg::PIN_CS], host_en[hpag_pkg::PIN_RS],
                      host_en[hpag_pkg::PIN_WR], host_en[hpag_pkg::PIN_RD]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hout_r <= '0;
    end
    else
    begin
      hout_r <= hout_nxt;
    end
  end

  assign host_out = hout_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wire logic rd_plain = rd_go & rs_act & host_in.byte_sel == 2'h0 & ~ctrl_r[hpag_pkg::CTRL_ORDER_BIT];

  property p_win_upper;
    @(posedge clk) disable iff (!rst_n)
    rd_plain & ~ctrl_r[hpag_pkg::CTRL_SWAP_BIT] |=> host_out.bus_oe && host_out.bus_out == $past(window_r[31:16]);
  endproperty
  a_win_upper: assert property (p_win_upper) else $error("window upper half not on bus");

  property p_win_swap;
    @(posedge clk) disable iff (!rst_n)
    rd_plain & ctrl_r[hpag_pkg::CTRL_SWAP_BIT]
      |=> host_out.bus_out == {$past(window_r[7:0]), $past(window_r[15:8])};
  endproperty
  a_win_swap: assert property (p_win_swap) else $error("swapped window half wrong");

  property p_aux_noswap;
    @(posedge clk) disable iff (!rst_n)
    rd_go & ~rs_act & host_in.byte_sel == 2'h2 & ~ctrl_r[hpag_pkg::CTRL_ORDER_BIT]
      |=> host_out.bus_out == $past(aux_r[15:0]);
  endproperty
  a_aux_noswap: assert property (p_aux_noswap) else $error("other register half wrong");

  property p_guard_off;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & ~power_guard_in
      |=> !host_out.ready_oe && !host_out.irq_oe && !host_out.dreq_oe && !host_out.bus_oe && host_out.in_en == 4'h0;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("pin driven while guard low");

  property p_boot_reset;
    @(posedge clk) disable iff (!rst_n)
    (~reset_pin_n & boot_strap_in) [*2]
      |=> host_out.ready_oe && !host_out.ready && !host_out.irq_oe && host_out.in_en == 4'h0;
  endproperty
  a_boot_reset: assert property (p_boot_reset) else $error("boot reset pin state wrong");

  property p_boot_live;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & boot_mode_r & power_guard_in
      |=> host_out.ready_oe && host_out.irq_oe && host_out.dreq_oe && host_out.in_en == 4'hf;
  endproperty
  a_boot_live: assert property (p_boot_live) else $error("boot mode pins not live");

  property p_nonboot_reset;
    @(posedge clk) disable iff (!rst_n)
    ~reset_pin_n & ~boot_strap_in |=> !host_out.ready_oe && host_out.in_en == 4'h0 && !host_out.bus_oe;
  endproperty
  a_nonboot_reset: assert property (p_nonboot_reset) else $error("non-boot reset pin not input");

  property p_cfg_guard;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & ~boot_mode_r & pfc_r[hpag_pkg::PIN_GUARD] & pfc_r[hpag_pkg::PIN_CS]
      |=> host_out.in_en[3] == $past(power_guard_in);
  endproperty
  a_cfg_guard: assert property (p_cfg_guard) else $error("configured pin ignores guard");

  property p_cfg_noguard;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & ~boot_mode_r & ~pfc_r[hpag_pkg::PIN_GUARD] |=> host_out.in_en == 4'h0 && !host_out.irq_oe;
  endproperty
  a_cfg_noguard: assert property (p_cfg_noguard) else $error("pin live without guard function");

  property p_host_win_write;
    @(posedge clk) disable iff (!rst_n)
    wr_go & rs_act & ~ctrl_r[hpag_pkg::CTRL_SWAP_BIT] & (host_in.byte_sel[1] ^ ctrl_r[hpag_pkg::CTRL_ORDER_BIT])
      |=> window_r[15:0] == $past(host_in.bus);
  endproperty
  a_host_win_write: assert property (p_host_win_write) else $error("host write missed lower window half");

  property p_bus_idle;
    @(posedge clk) disable iff (!rst_n)
    ~rd_go |=> !host_out.bus_oe;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("data bus driven without read strobes");

  property p_boot_dreq;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & boot_mode_r & power_guard_in |=> host_out.dreq == $past(ctrl_r[hpag_pkg::CTRL_DREQ_BIT]);
  endproperty
  a_boot_dreq: assert property (p_boot_dreq) else $error("dma request level not sequenced");

  property p_boot_irq;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & boot_mode_r & power_guard_in |=> host_out.irq == $past(ctrl_r[hpag_pkg::CTRL_IRQ_BIT]);
  endproperty
  a_boot_irq: assert property (p_boot_irq) else $error("interrupt level not sequenced");

  property p_reset_quiet;
    @(posedge clk) disable iff (!rst_n)
    ~reset_pin_n & boot_strap_in |=> !host_out.bus_oe && !host_out.dreq_oe && !host_out.irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("boot reset drives bus or requests");

  property p_noguard_bus;
    @(posedge clk) disable iff (!rst_n)
    reset_pin_n & ~boot_mode_r & ~pfc_r[hpag_pkg::PIN_GUARD] & pfc_r[hpag_pkg::PIN_BUS]
      |=> !host_out.bus_oe && !host_out.dreq_oe;
  endproperty
  a_noguard_bus: assert property (p_noguard_bus) else $error("bus live without guard function");

  c_win_read: cover property (@(posedge clk) disable iff (!rst_n) rd_go & rs_act ##1 host_out.bus_oe);
  c_boot_up: cover property (@(posedge clk) disable iff (!rst_n) ~reset_pin_n & boot_strap_in ##1 reset_pin_n);
  c_cfg_live: cover property (@(posedge clk) disable iff (!rst_n) ~boot_mode_r & cfg_live & pfc_r[hpag_pkg::PIN_RD]);
  c_host_write: cover property (@(posedge clk) disable iff (!rst_n) wr_go & rs_act);
  c_guard_cut: cover property (@(posedge clk) disable iff (!rst_n)
                               reset_pin_n & power_guard_in ##1 ~power_guard_in);

endmodule : hpag_top

// file: hw/hpag_pkg.sv
package hpag_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets, byte addresses on the wishbone bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PINCFG_OFS = 8'h04;
  localparam logic [7:0] WINDOW_OFS = 8'h08;
  localparam logic [7:0] AUX_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RAWBUS_OFS = 8'h14;

  // control register fields
  localparam int CTRL_SWAP_BIT = 0;
  localparam int CTRL_ORDER_BIT = 1;
  localparam int CTRL_READY_BIT = 2;
  localparam int CTRL_IRQ_BIT = 3;
  localparam int CTRL_DREQ_BIT = 4;
  localparam int CTRL_W = 5;

  // pin function config fields, one bit per host-port pin group, one bit for all 16 bus lines, none for byte select
  localparam int PIN_GUARD = 0;
  localparam int PIN_READY = 1;
  localparam int PIN_IRQ = 2;
  localparam int PIN_DREQ = 3;
  localparam int PIN_BUS = 4;
  localparam int PIN_CS = 5;
  localparam int PIN_RS = 6;
  localparam int PIN_WR = 7;
  localparam int PIN_RD = 8;
  localparam int PIN_W = 9;

  // status register fields
  localparam int STAT_BOOT_BIT = 0;
  localparam int STAT_GUARD_BIT = 1;
  localparam int STAT_RESET_BIT = 2;
  localparam int STAT_RAW_LSB = 8;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [PIN_W-1:0] PINCFG_RST = 9'h000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // host pin bundles
  typedef struct packed {
    logic select_n;
    logic reg_select;
    logic write_n;
    logic read_n;
    logic [1:0] byte_sel;
    logic [15:0] bus;
  } hpag_host_in_type;

  typedef struct packed {
    logic ready;
    logic ready_oe;
    logic irq;
    logic irq_oe;
    logic dreq;
    logic dreq_oe;
    logic [15:0] bus_out;
    logic bus_oe;
    logic [3:0] in_en;
  } hpag_host_out_type;

  ////////////////////////////////////////////////////////////////////////////
  // reverse the four bytes of a word
  function automatic logic [31:0] byte_rev(input logic [31:0] w);
    byte_rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : byte_rev

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
    begin
      lane_merge[i*8 +: 8] = sel[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    end
  endfunction : lane_merge

endpackage : hpag_pkg

// file: hw/hpag_lane.sv
// halfword pick and merge for one 32-bit host register
module hpag_lane (
  input wire logic [31:0] word,
  input wire logic swap,
  input wire logic order_inv,
  input wire logic byte_sel_hi,
  input wire logic [15:0] bus_in,
  output logic [15:0] half_out,
  output logic [31:0] word_merged
);

  logic [31:0] view;
  logic pick_lower;
  logic [31:0] view_merged;

  // byte-reversed view when swapping, then halfword choice
  assign view = swap ? hpag_pkg::byte_rev(word) : word;
  assign pick_lower = byte_sel_hi ^ order_inv;
  assign half_out = pick_lower ? view[15:0] : view[31:16];
  assign view_merged = pick_lower ? {view[31:16], bus_in} : {bus_in, view[15:0]};
  assign word_merged = swap ? hpag_pkg::byte_rev(view_merged) : view_merged;

endmodule : hpag_lane

// file: verif/hpag_host_model.sv
// external host cpu and its power monitor on the parallel port
module hpag_host_model (
  input wire logic clk,
  input wire hpag_pkg::hpag_host_out_type host_out,
  output hpag_pkg::hpag_host_in_type host_in,
  output logic power_guard
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_on = 1'b0;
  logic [15:0] wr_data = 16'h0000;

  // idle host: strobes released, guard low
  initial
  begin
    host_in = {1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 16'hffff};
    power_guard = 1'b0;
  end

  // undriven bus lines flip every cycle, never a stale value; held while writing
  always @(posedge clk)
  begin
    host_in.bus <= wr_on ? wr_data : ~host_in.bus;
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor moves guard together with host supply
  task automatic set_power(input logic on);
    @(posedge clk);
    power_guard <= on;
  endtask : set_power

  // one halfword read, held until the device drives the bus
  task automatic rd(input logic win, input logic [1:0] bsel, output logic [15:0] d);
    @(posedge clk);
    host_in.select_n <= 1'b0;
    host_in.read_n <= 1'b0;
    host_in.reg_select <= win;
    host_in.byte_sel <= bsel;
    do
    begin
      @(posedge clk);
    end
    while (host_out.bus_oe !== 1'b1);
    d = host_out.bus_out;
    host_in.select_n <= 1'b1;
    host_in.read_n <= 1'b1;
    @(posedge clk);
  endtask : rd

  // one halfword write; data reaches the bus with the strobes and is held a cycle after them
  task automatic wr(input logic win, input logic [1:0] bsel, input logic [15:0] d);
    @(posedge clk);
    wr_data <= d;
    wr_on <= 1'b1;
    host_in.reg_select <= win;
    host_in.byte_sel <= bsel;
    @(posedge clk);
    host_in.select_n <= 1'b0;
    host_in.write_n <= 1'b0;
    @(posedge clk);
    host_in.select_n <= 1'b1;
    host_in.write_n <= 1'b1;
    wr_on <= 1'b0;
    @(posedge clk);
  endtask : wr
endmodule : hpag_host_model

// file: verif/hpag_tb_top.sv
module hpag_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b0;
  logic boot_strap_in = 1'b1;
  logic power_guard_in;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wsel = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] rdat;
  logic [15:0] half;
  hpag_pkg::hpag_host_in_type host_in;
  hpag_pkg::hpag_host_out_type host_out;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 20 mhz clock
  always #25 clk = ~clk;

  hpag_top i_hpag_top (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .boot_strap_in(boot_strap_in),
    .power_guard_in(power_guard_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .host_in(host_in), .host_out(host_out));
  hpag_host_model i_hpag_host_model (.clk(clk), .host_out(host_out), .host_in(host_in),
    .power_guard(power_guard_in));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= wsel;
    do
    begin
      @(posedge clk);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // gating outputs packed for comparison, then a settled compare
  task automatic chk_pins(input string what, input logic [10:0] exp);
    repeat (3) @(posedge clk);
    chk(what, {21'h0, host_out.ready, host_out.ready_oe, host_out.irq, host_out.irq_oe, host_out.dreq,
      host_out.dreq_oe, host_out.bus_oe, host_out.in_en}, {21'h0, exp});
  endtask : chk_pins

  ////////////////////////////////////////////////////////////////////////////
  // held in reset with boot strap: only ready driven low
  task automatic t_boot_reset;
    i_hpag_host_model.set_power(1'b0);
    chk_pins("reset guard low", 11'h200);
    i_hpag_host_model.set_power(1'b1);
    chk_pins("reset guard high", 11'h200);
    $display("done boot reset");
  endtask : t_boot_reset

  // boot mode after reset follows the guard
  task automatic t_boot_run;
    @(posedge clk);
    reset_pin_n <= 1'b1;
    chk_pins("boot guard high", 11'h2af);
    i_hpag_host_model.set_power(1'b0);
    chk_pins("boot guard low", 11'h000);
    i_hpag_host_model.set_power(1'b1);
    wb(1'b1, hpag_pkg::CTRL_OFS, 32'h0000_001c, rdat);
    chk_pins("boot outputs on", 11'h7ef);
    $display("done boot run");
  endtask : t_boot_run

  // every swap, order and select combination on window and other register
  task automatic t_align;
    logic [31:0] w;
    wb(1'b1, hpag_pkg::WINDOW_OFS, 32'h7654_3210, rdat);
    wb(1'b1, hpag_pkg::AUX_OFS, 32'h7654_3210, rdat);
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b1, hpag_pkg::CTRL_OFS, {30'h0, i[1], i[0]}, rdat);
      i_hpag_host_model.rd(i[3], {i[2], 1'b0}, half);
      w = (i[0] && i[3]) ? 32'h1032_5476 : 32'h7654_3210;
      chk("aligned half", {16'h0, half}, {16'h0, (i[2] ^ i[1]) ? w[15:0] : w[31:16]});
    end
    $display("done align");
  endtask : t_align

  // strap low: general inputs until pin config, then guard gating
  task automatic t_nonboot;
    @(posedge clk);
    reset_pin_n <= 1'b0;
    boot_strap_in <= 1'b0;
    chk_pins("nonboot reset", 11'h000);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    chk_pins("nonboot guard high", 11'h000);
    wb(1'b1, hpag_pkg::PINCFG_OFS, 32'h0000_01ff, rdat);
    wb(1'b1, hpag_pkg::CTRL_OFS, 32'h0000_001c, rdat);
    chk_pins("configured live", 11'h7ef);
    i_hpag_host_model.rd(1'b1, 2'h0, half);
    chk("configured read", {16'h0, half}, 32'h0000_7654);
    i_hpag_host_model.wr(1'b1, 2'h2, 16'ha5c3);
    wb(1'b0, hpag_pkg::WINDOW_OFS, 32'h0, rdat);
    chk("host window write", rdat, 32'h7654_a5c3);
    wsel = 4'h2;
    wb(1'b1, hpag_pkg::AUX_OFS, 32'hffff_eeff, rdat);
    wsel = 4'hf;
    wb(1'b0, hpag_pkg::AUX_OFS, 32'h0, rdat);
    chk("byte lane write", rdat, 32'h7654_ee10);
    i_hpag_host_model.set_power(1'b0);
    chk_pins("configured guard low", 11'h000);
    wb(1'b1, hpag_pkg::PINCFG_OFS, 32'h0000_01fe, rdat);
    i_hpag_host_model.set_power(1'b1);
    chk_pins("pins without guard", 11'h000);
    wb(1'b0, 8'h18, 32'h0, rdat);
    chk("unmapped read", rdat, 32'h0000_0000);
    wb(1'b0, hpag_pkg::PINCFG_OFS, 32'h0, rdat);
    chk("pin config read", rdat, 32'h0000_01fe);
    wb(1'b0, hpag_pkg::STATUS_OFS, 32'h0, rdat);
    chk("raw pin status", rdat, 32'h0000_1f02);
    $display("done nonboot");
  endtask : t_nonboot

  ////////////////////////////////////////////////////////////////////////////
  // cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done();
    end
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_boot_reset();
    t_boot_run();
    t_align();
    t_nonboot();
    test_done();
  end
endmodule : hpag_tb_top
